// *** bench/tb_rx_line_control_regs.sv ***
/*
  Self-checking bench for the receive line control register bank.
  Assumes the bank's top module answers AXI4-Lite on a 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rxlc_consts.svh"

module tb_rx_line_control_regs
  import rxlc_pkg::*;
;
  logic        aclk, aresetn, host_mode_pin;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [8:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, rx_section_on, rx_term_internal_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [19:0] eq_code;
  logic [27:0] term_jitter_other;
  logic [7:0]  r0 [4];
  logic [7:0]  r1 [4];
  logic [7:0]  v0 [4] = '{8'h3F, 8'h80, 8'h61, 8'h0A};
  logic [7:0]  v1 [4] = '{8'h80, 8'h7F, 8'h81, 8'h55};
  int          n_errors = 0;
  int          n_tests = 0;

  rxlc_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .host_mode_pin(host_mode_pin),
    .rx_section_on(rx_section_on), .eq_code(eq_code),
    .rx_term_internal_sel(rx_term_internal_sel), .term_jitter_other(term_jitter_other)
  );

  always #10 aclk = ~aclk;

  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Byte address of a channel register: index times four.
  function automatic logic [8:0] ra(input logic [1:0] ch, input logic sel);
    return {1'b0, ch, 3'b000, sel, 2'b00};
  endfunction

  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    chk("rdata", {24'h0, ed}, s_axi_rdata);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Channel outputs follow the stored bytes; hardware mode forces receivers on.
  task automatic chk_outs();
    logic [19:0] eq;
    logic [3:0]  on;
    logic [3:0]  ts;
    logic [27:0] ot;
    for (int n = 0; n < 4; n++) begin
      eq[5*n+:5] = r0[n][4:0];
      on[n] = r0[n][5] | ~host_mode_pin;
      ts[n] = r1[n][7];
      ot[7*n+:7] = r1[n][6:0];
    end
    chk("rx_section_on", {28'h0, on}, {28'h0, rx_section_on});
    chk("eq_code", {12'h0, eq}, {12'h0, eq_code});
    chk("rx_term_internal_sel", {28'h0, ts}, {28'h0, rx_term_internal_sel});
    chk("term_jitter_other", {4'h0, ot}, {4'h0, term_jitter_other});
  endtask

  task automatic rd_all();
    for (int n = 0; n < 4; n++) begin
      rd(ra(2'(n), 1'b0), r0[n], rxlc_resp_okay);
      rd(ra(2'(n), 1'b1), r1[n], rxlc_resp_okay);
    end
  endtask

  task automatic set_mode(input logic h);
    host_mode_pin <= h;
    repeat (5) @(posedge aclk);
    chk_outs();
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    host_mode_pin = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 9'h000;
    s_axi_araddr = 9'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    for (int n = 0; n < 4; n++) begin
      r0[n] = 8'h00;
      r1[n] = 8'h00;
    end
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk_outs();
    rd_all();
    r0[0] = 8'h1F;
    wr(ra(0, 1'b0), r0[0], 4'h1, rxlc_resp_okay);
    chk_outs();
    $display("test reset_and_hardware_mode done");
    set_mode(1'b1);
    for (int n = 0; n < 4; n++) begin
      r0[n] = v0[n];
      r1[n] = v1[n];
      wr(ra(2'(n), 1'b0), v0[n], 4'h1, rxlc_resp_okay);
      wr(ra(2'(n), 1'b1), v1[n], 4'h1, rxlc_resp_okay);
      chk_outs();
    end
    rd_all();
    $display("test program_channels done");
    r0[2] = 8'h41;
    wr(ra(2, 1'b0), r0[2], 4'h1, rxlc_resp_okay);
    chk_outs();
    r0[1] = 8'hA0;
    wr(ra(1, 1'b0), r0[1], 4'h1, rxlc_resp_okay);
    chk_outs();
    $display("test independent_receivers done");
    set_mode(1'b0);
    rd_all();
    set_mode(1'b1);
    $display("test mode_switch done");
    wr(9'h008, 8'hFF, 4'h1, rxlc_resp_slverr);
    wr(9'h100, 8'hFF, 4'h1, rxlc_resp_slverr);
    rd(9'h008, 8'h00, rxlc_resp_slverr);
    rd(9'h100, 8'h00, rxlc_resp_slverr);
    wr(ra(3, 1'b0), 8'hFF, 4'hE, rxlc_resp_okay);
    chk_outs();
    rd_all();
    $display("test unmapped_and_strobe done");
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire

// *** logic/rxlc_chan_regs.sv ***
/*
  One channel's pair of control registers and their decoded outputs.
  Assumes write strobes and the mode level are already on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rxlc_consts.svh"

module rxlc_chan_regs
  import rxlc_pkg::*;
(
  input  wire logic             aclk,         // System clock.
  input  wire logic             aresetn,      // Synchronous reset, active low.
  input  wire logic             wr_reg0,      // Write pulse for register 0.
  input  wire logic             wr_reg1,      // Write pulse for register 1.
  input  wire rxlc_byte_t       wr_byte,      // Byte to be written.
  input  wire logic             host_mode,    // High in host mode.
  output rxlc_byte_t            reg0,         // Register 0 content.
  output rxlc_byte_t            reg1,         // Register 1 content.
  output logic                  rx_section_on // Effective receiver enable.
);
  rxlc_byte_t next_reg0;
  rxlc_byte_t next_reg1;
  logic       next_rx_on;

  assign next_reg0  = wr_reg0 ? wr_byte : reg0;
  assign next_reg1  = wr_reg1 ? wr_byte : reg1;
  assign next_rx_on = host_mode ? next_reg0[`RXLC_RX_ON_BIT] : 1'b1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg0          <= `RXLC_REG0_RST;
      reg1          <= `RXLC_REG1_RST;
      rx_section_on <= 1'b1;
    end else begin
      reg0          <= next_reg0;
      reg1          <= next_reg1;
      rx_section_on <= next_rx_on;
    end
  end
endmodule

`default_nettype wire

// *** logic/rxlc_consts.svh ***
/*
  Constants of the per-channel receive line control register bank.
  Assumes inclusion by bare name from the package and the design modules.
*/
//
// Summary of operation
// - Four channels each decode register 0 and 1.
// - Register 0 bit 5 switches channel receiver.
// - Each receiver enable affects its own channel.
// - Hardware mode keeps every receiver always on.
// - Register 0 bits 4..0 hold equalizer code.
// - Register 1 bit 7 selects internal termination.
`ifndef RXLC_CONSTS_SVH
`define RXLC_CONSTS_SVH

`define RXLC_NCH          4
`define RXLC_CH_W         2
`define RXLC_IDX_W        7
`define RXLC_ADDR_W       9
`define RXLC_DATA_W       32
`define RXLC_STRB_W       4
`define RXLC_REG_W        8
`define RXLC_BYTE_LSB     2
`define RXLC_IDX_TOP      6
`define RXLC_IDX_CH_MSB   5
`define RXLC_IDX_CH_LSB   4
`define RXLC_IDX_PAD_MSB  3
`define RXLC_IDX_PAD_LSB  1
`define RXLC_IDX_SEL      0
`define RXLC_CH0_REG0_IDX 7'h00
`define RXLC_CH0_REG1_IDX 7'h01
`define RXLC_CH1_REG0_IDX 7'h10
`define RXLC_CH1_REG1_IDX 7'h11
`define RXLC_CH2_REG0_IDX 7'h20
`define RXLC_CH2_REG1_IDX 7'h21
`define RXLC_CH3_REG0_IDX 7'h30
`define RXLC_CH3_REG1_IDX 7'h31
`define RXLC_RX_ON_BIT    5
`define RXLC_EQ_MSB       4
`define RXLC_EQ_LSB       0
`define RXLC_EQ_W         5
`define RXLC_RSVD_MSB     7
`define RXLC_RSVD_LSB     6
`define RXLC_TERM_BIT     7
`define RXLC_REG0_RST     8'h00
`define RXLC_REG1_RST     8'h00

`endif

// *** logic/rxlc_pkg.sv ***
/*
  Types shared by the receive line control register bank.
  Assumes the constants header is on the include path.
*/
`default_nettype none
`include "rxlc_consts.svh"

package rxlc_pkg;
  typedef logic [`RXLC_REG_W-1:0] rxlc_byte_t;
  typedef enum logic [1:0] {
    rxlc_resp_okay   = 2'b00,
    rxlc_resp_slverr = 2'b10
  } rxlc_resp_t;
endpackage

`default_nettype wire

// *** logic/rxlc_top.sv ***
/*
  AXI4-Lite slave holding four channels of receive line control registers.
  Assumes a single 50 MHz clock and a host mode strap from an outside pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rxlc_consts.svh"

module rxlc_top
  import rxlc_pkg::*;
#(
  parameter int NCH = `RXLC_NCH
)
(
  input  wire logic                        aclk,                 // System clock.
  input  wire logic                        aresetn,              // Synchronous reset, low.
  input  wire logic [`RXLC_ADDR_W-1:0]     s_axi_awaddr,         // Write address.
  input  wire logic [2:0]                  s_axi_awprot,         // Write protection.
  input  wire logic                        s_axi_awvalid,        // Write address valid.
  output logic                             s_axi_awready,        // Write address ready.
  input  wire logic [`RXLC_DATA_W-1:0]     s_axi_wdata,          // Write data.
  input  wire logic [`RXLC_STRB_W-1:0]     s_axi_wstrb,          // Write strobes.
  input  wire logic                        s_axi_wvalid,         // Write data valid.
  output logic                             s_axi_wready,         // Write data ready.
  output logic [1:0]                       s_axi_bresp,          // Write response.
  output logic                             s_axi_bvalid,         // Write response valid.
  input  wire logic                        s_axi_bready,         // Write response ready.
  input  wire logic [`RXLC_ADDR_W-1:0]     s_axi_araddr,         // Read address.
  input  wire logic [2:0]                  s_axi_arprot,         // Read protection.
  input  wire logic                        s_axi_arvalid,        // Read address valid.
  output logic                             s_axi_arready,        // Read address ready.
  output logic [`RXLC_DATA_W-1:0]          s_axi_rdata,          // Read data.
  output logic [1:0]                       s_axi_rresp,          // Read response.
  output logic                             s_axi_rvalid,         // Read data valid.
  input  wire logic                        s_axi_rready,         // Read data ready.
  input  wire logic                        host_mode_pin,        // Strap, high for host mode.
  output logic [NCH-1:0]                   rx_section_on,        // Receiver enable per channel.
  output logic [NCH*`RXLC_EQ_W-1:0]        eq_code,              // Equalizer code per channel.
  output logic [NCH-1:0]                   rx_term_internal_sel, // Internal termination select.
  output logic [NCH*(`RXLC_REG_W-1)-1:0]   term_jitter_other     // Register 1 bits 6..0.
);
  // Strap synchroniser; only the second stage is read by logic.
  logic host_meta;
  logic host_sync;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_meta <= 1'b0;
      host_sync <= 1'b0;
    end else begin
      host_meta <= host_mode_pin;
      host_sync <= host_meta;
    end
  end

  // Write channel holding state.
  logic                   aw_held;
  logic                   w_held;
  logic [`RXLC_IDX_W-1:0] w_idx;
  rxlc_byte_t             w_byte;
  logic                   w_lane0;
  logic                   aw_hs;
  logic                   w_hs;
  logic                   do_write;
  logic                   next_aw_held;
  logic                   next_w_held;
  logic                   next_bvalid;
  logic                   next_awready;
  logic                   next_wready;

  assign aw_hs        = s_axi_awvalid & s_axi_awready;
  assign w_hs         = s_axi_wvalid & s_axi_wready;
  assign do_write     = aw_held & w_held & ~s_axi_bvalid;
  assign next_aw_held = (aw_held | aw_hs) & ~do_write;
  assign next_w_held  = (w_held | w_hs) & ~do_write;
  assign next_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign next_awready = ~next_aw_held & ~next_bvalid;
  assign next_wready  = ~next_w_held & ~next_bvalid;

  // Decode of the held write index into channel and register select.
  logic                 w_map;
  logic [`RXLC_CH_W-1:0] w_ch;
  logic                 w_sel1;
  logic                 w_lane_ok;

  assign w_map  = ~w_idx[`RXLC_IDX_TOP] &
                  (w_idx[`RXLC_IDX_PAD_MSB:`RXLC_IDX_PAD_LSB] == 3'h0);
  assign w_ch   = w_idx[`RXLC_IDX_CH_MSB:`RXLC_IDX_CH_LSB];
  assign w_sel1 = w_idx[`RXLC_IDX_SEL];
  assign w_lane_ok = do_write & w_map & w_lane0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= rxlc_resp_okay;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      if (do_write) begin
        s_axi_bresp <= w_map ? rxlc_resp_okay : rxlc_resp_slverr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_idx   <= `RXLC_CH0_REG0_IDX;
      w_byte  <= `RXLC_REG0_RST;
      w_lane0 <= 1'b0;
    end else begin
      if (aw_hs) begin
        w_idx <= s_axi_awaddr[`RXLC_ADDR_W-1:`RXLC_BYTE_LSB];
      end
      if (w_hs) begin
        w_byte  <= s_axi_wdata[`RXLC_REG_W-1:0];
        w_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  // Channel register instances.
  rxlc_byte_t reg0_q [NCH];
  rxlc_byte_t reg1_q [NCH];
  logic [NCH-1:0] wr0;
  logic [NCH-1:0] wr1;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign wr0[g] = w_lane_ok & (w_ch == `RXLC_CH_W'(g)) & ~w_sel1;
    assign wr1[g] = w_lane_ok & (w_ch == `RXLC_CH_W'(g)) & w_sel1;

    rxlc_chan_regs u_chan (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .wr_reg0       (wr0[g]),
      .wr_reg1       (wr1[g]),
      .wr_byte       (w_byte),
      .host_mode     (host_sync),
      .reg0          (reg0_q[g]),
      .reg1          (reg1_q[g]),
      .rx_section_on (rx_section_on[g])
    );

    assign eq_code[g*`RXLC_EQ_W +: `RXLC_EQ_W] = reg0_q[g][`RXLC_EQ_MSB:`RXLC_EQ_LSB];
    assign rx_term_internal_sel[g] = reg1_q[g][`RXLC_TERM_BIT];
    assign term_jitter_other[g*(`RXLC_REG_W-1) +: (`RXLC_REG_W-1)] =
      reg1_q[g][`RXLC_REG_W-2:0];
  end

  // Read channel.
  logic [`RXLC_IDX_W-1:0] r_idx;
  logic                  r_map;
  logic [`RXLC_CH_W-1:0] r_ch;
  rxlc_byte_t            r_byte;
  logic                  ar_hs;
  logic                  next_rvalid;

  assign ar_hs       = s_axi_arvalid & s_axi_arready;
  assign next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  assign r_idx       = s_axi_araddr[`RXLC_ADDR_W-1:`RXLC_BYTE_LSB];
  assign r_map  = ~r_idx[`RXLC_IDX_TOP] &
                  (r_idx[`RXLC_IDX_PAD_MSB:`RXLC_IDX_PAD_LSB] == 3'h0);
  assign r_ch   = r_idx[`RXLC_IDX_CH_MSB:`RXLC_IDX_CH_LSB];
  assign r_byte = !r_map ? 8'h00 :
                  r_idx[`RXLC_IDX_SEL] ? reg1_q[r_ch] : reg0_q[r_ch];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= rxlc_resp_okay;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_hs) begin
        s_axi_rdata <= {{(`RXLC_DATA_W-`RXLC_REG_W){1'b0}}, r_byte};
        s_axi_rresp <= r_map ? rxlc_resp_okay : rxlc_resp_slverr;
      end
    end
  end

  // Checks next to the logic that they guard.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // unmapped writes answer with an error
  a_write_decode: assert property (do_write |=>
    s_axi_bvalid && ((s_axi_bresp == rxlc_resp_okay) == $past(w_map)))
    else $error("write response does not match address decode");

  // read answers next cycle with decode
  a_read_decode: assert property (ar_hs |=>
    s_axi_rvalid && ((s_axi_rresp == rxlc_resp_okay) == $past(r_map)))
    else $error("read response does not match address decode");

  a_rx_on_write: assert property (host_sync && wr0[0] |=>
    rx_section_on[0] == $past(w_byte[`RXLC_RX_ON_BIT]))
    else $error("channel 0 receiver enable did not follow write");

  a_chan_isolated: assert property (wr0[0] && host_sync |=>
    $stable(rx_section_on[NCH-1:1]) || !$past(host_sync, 2))
    else $error("write to channel 0 changed another receiver");

  a_hw_mode_on: assert property (!host_sync |=>
    rx_section_on == {NCH{1'b1}})
    else $error("receiver off in hardware mode");

  a_eq_write: assert property (wr0[NCH-1] |=>
    eq_code[(NCH-1)*`RXLC_EQ_W +: `RXLC_EQ_W] == $past(w_byte[`RXLC_EQ_MSB:`RXLC_EQ_LSB]))
    else $error("equalizer code did not follow write");

  a_term_write: assert property (wr1[1] |=>
    rx_term_internal_sel[1] == $past(w_byte[`RXLC_TERM_BIT]))
    else $error("termination select did not follow write");

  // reserved bits of channel 2 register 0 store the written value
  a_rsvd_store: assert property (wr0[2] |=>
    reg0_q[2][`RXLC_RSVD_MSB:`RXLC_RSVD_LSB] == $past(w_byte[`RXLC_RSVD_MSB:`RXLC_RSVD_LSB]))
    else $error("reserved bits not stored");

  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");

  a_aw_refused: assert property (aw_held || s_axi_bvalid |->
    !s_axi_awready)
    else $error("write address ready while a write is pending");

  a_w_refused: assert property (w_held || s_axi_bvalid |->
    !s_axi_wready)
    else $error("write data ready while a write is pending");

  a_ar_refused: assert property (s_axi_rvalid |->
    !s_axi_arready)
    else $error("read address ready while read data is pending");

  a_b_reopen: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channels not reopened after response");

  a_r_reopen: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready)
    else $error("read address channel not reopened after data");

  a_rdata_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[`RXLC_DATA_W-1:`RXLC_REG_W] == '0)
    else $error("read data upper bits not zero");

  a_strobe_skip: assert property (do_write && !w_lane0 |=>
    $stable(eq_code) && $stable(rx_term_internal_sel) && $stable(term_jitter_other))
    else $error("write with lane 0 disabled changed a register");

  a_unmapped_read: assert property (ar_hs && !r_map |=>
    s_axi_rdata == '0)
    else $error("unmapped read returned data");

  a_unmapped_write: assert property (do_write && !w_map |=>
    $stable(eq_code) && $stable(rx_term_internal_sel) && $stable(term_jitter_other))
    else $error("unmapped write changed a register");

  a_eq_isolated: assert property (wr0[NCH-1] |=>
    $stable(eq_code[(NCH-1)*`RXLC_EQ_W-1:0]))
    else $error("equalizer write reached another channel");

  a_term_isolated: assert property (wr1[1] |=>
    $stable(rx_term_internal_sel[0]) && $stable(rx_term_internal_sel[NCH-1:2]))
    else $error("termination write reached another channel");

  a_rx_hold: assert property (host_sync && !wr0[0] |=>
    $stable(rx_section_on[0]) || !$past(host_sync, 2))
    else $error("channel 0 receiver enable changed without a write");

  c_write_ok: cover property (do_write && w_map && w_lane0);
  c_write_err: cover property (do_write && !w_map);
  c_read_back: cover property (ar_hs && r_map ##1 s_axi_rvalid && s_axi_rready);
  c_hw_mode: cover property (!host_sync ##1 host_sync);
  c_strobe_skip: cover property (do_write && w_map && !w_lane0);
endmodule

`default_nettype wire
